// file: rtl/sbc_config_diag_encoder.sv
// Serial configuration, watchdog set-up and restart-cause diagnosis registers
// What this block does
// - Slope bit defaults one, selects low slope
// - CAN mode field, default off, four modes
// - LIN mode field, default off, four modes
// - Watchdog type and enable both default one
// - Bad check bit discards whole watchdog write
// - Select code 111 only returns diagnosis
// - Threshold code 00 rejected, previous kept
// - Period code maps to documented millisecond value
// - Restart cause field reports three causes, code 00 none
// - Read-only diagnosis read clears restart cause
// - Leaving sleep or fail-safe clears cause
// - Diagnosis encodings taken from the input ports
// - Read-only answers same frame, others next
// - Read-only never writes, still triggers watchdog
`timescale 1ns/1ps
module sbc_config_diag_encoder
  import sbc_cfg_pkg::*;
(
  input wire logic MCLK,
  input wire logic RST,
  input wire logic SCLK,
  input wire logic CS_N,
  input wire logic SDI,
  output logic SDO,
  input wire logic RESTART_SET,
  input wire logic [1:0] RESTART_CODE,
  input wire logic MODE_EXIT,
  input wire logic [2:0] LIMP_CAUSE,
  input wire logic [2:0] CONFIG_READOUT,
  output logic LIN_LOW_SLOPE,
  output logic [1:0] CAN_MODE,
  output logic [1:0] LIN_MODE,
  output logic WD_TIMEOUT_MODE,
  output logic WD_ENABLE,
  output logic [10:0] WD_PERIOD_MS,
  output logic [1:0] RESET_THRESHOLD,
  output logic [1:0] RESTART_CAUSE,
  output logic WD_TRIGGER
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  // Period code to milliseconds
  function automatic logic [10:0] period_ms(input logic [4:0] code);
    logic [10:0] n;
    n = {6'h00, code};
    if (code[4]) begin
      period_ms = 11'(n * PERIOD_STEP_HI) - PERIOD_OFFSET;
    end else begin
      period_ms = 11'((n + 11'h001) * PERIOD_STEP_LO);
    end
  endfunction

  // Shadow state visible to the link side during a frame
  logic [9:0] sh_cfg_ff, sh_comm_ff, sh_wd_ff, sh_diag_ff;
  logic [2:0] sh_cs_ff;

  // Data field of a register chosen by its select code
  function automatic logic [9:0] pick(input logic [2:0] cs);
    case (cs)
      CS_CONFIG: pick = sh_cfg_ff;
      CS_COMM: pick = sh_comm_ff;
      CS_WATCHDOG: pick = sh_wd_ff;
      CS_DIAG: pick = sh_diag_ff;
      default: pick = 10'h000;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Link side, clocked by SCLK
  // ---------------------------------------------------------------
  logic link_rst;
  logic [4:0] cnt_ff;
  logic [15:0] rx_ff;
  logic [15:0] frame_ff;
  logic done_tgl_ff;
  logic sdo_ff;
  logic ro_live;
  logic [15:0] out_word;
  logic [3:0] out_idx;

  // Frame gate: deselect clears the receive state
  assign link_rst = RST | CS_N;

  // Receive bits LSB first, extra bits ignored
  always_ff @(posedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      cnt_ff <= 5'h00;
      rx_ff <= 16'h0000;
    end else if (cnt_ff < 5'(FRAME_BITS)) begin
      rx_ff[cnt_ff[3:0]] <= SDI;
      cnt_ff <= cnt_ff + 5'h01;
    end
  end

  // Capture a complete frame and flag it by a toggle
  always_ff @(posedge SCLK or posedge RST) begin
    if (RST) begin
      frame_ff <= 16'h0000;
      done_tgl_ff <= 1'b0;
    end else if (!CS_N && cnt_ff == 5'(FRAME_BITS - 1)) begin
      frame_ff <= {SDI, rx_ff[14:0]};
      done_tgl_ff <= ~done_tgl_ff;
    end
  end

  // same-frame answer
  // Read-only swaps in the selected data once its select is known
  assign ro_live = (cnt_ff >= 5'(DATA_LSB)) && (rx_ff[2:0] == MS_READ_ONLY);
  assign out_word = ro_live ? {pick(rx_ff[5:3]), rx_ff[5:3], 3'h0}
                            : {pick(sh_cs_ff), sh_cs_ff, 3'h0};
  assign out_idx = cnt_ff[4] ? 4'h0 : cnt_ff[3:0];

  // Output bit changes on the falling edge, bit 0 shows at select
  always_ff @(negedge SCLK or posedge link_rst) begin
    if (link_rst) begin
      sdo_ff <= 1'b0;
    end else begin
      sdo_ff <= out_word[out_idx];
    end
  end

  assign SDO = sdo_ff;

  // ---------------------------------------------------------------
  // Crossing into the MCLK domain
  // ---------------------------------------------------------------
  logic csn_s1_ff, csn_s2_ff;
  logic tgl_s1_ff, tgl_s2_ff, tgl_s3_ff;
  logic frame_ev;

  // Two-stage synchronisers for select level and frame toggle
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      csn_s1_ff <= 1'b1;
      csn_s2_ff <= 1'b1;
      tgl_s1_ff <= 1'b0;
      tgl_s2_ff <= 1'b0;
      tgl_s3_ff <= 1'b0;
    end else begin
      csn_s1_ff <= CS_N;
      csn_s2_ff <= csn_s1_ff;
      tgl_s1_ff <= done_tgl_ff;
      tgl_s2_ff <= tgl_s1_ff;
      tgl_s3_ff <= tgl_s2_ff;
    end
  end

  assign frame_ev = tgl_s2_ff ^ tgl_s3_ff;

  // ---------------------------------------------------------------
  // Frame decode, MCLK domain
  // ---------------------------------------------------------------
  logic [2:0] f_ms, f_cs;
  logic f_ro, wd_chk_ok;
  logic wr_comm, wr_wd, wr_thr, clr_cause;
  logic [1:0] f_thr;

  assign f_ms = frame_ff[MS_LSB +: 3];
  assign f_cs = frame_ff[CS_LSB +: 3];
  assign f_ro = (f_ms == MS_READ_ONLY);
  assign f_thr = frame_ff[THR_LSB +: 2];
  // check over bits 13 down to 6
  assign wd_chk_ok = (^frame_ff[CHK_HI:CHK_LO]) == frame_ff[WD_CHECK_BIT];
  assign wr_comm = frame_ev && !f_ro && (f_cs == CS_COMM);
  assign wr_wd = frame_ev && !f_ro && (f_cs == CS_WATCHDOG) && wd_chk_ok;
  assign wr_thr = frame_ev && !f_ro && (f_cs == CS_CONFIG) && (f_thr != THR_INVALID);
  // clear on read-only diagnosis read or mode exit
  assign clr_cause = (frame_ev && f_ro && (f_cs == CS_DIAG)) || MODE_EXIT;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic lin_low_slope_ff, wd_type_ff, wd_en_ff, wd_trig_ff;
  logic [1:0] can_mode_ff, lin_mode_ff, thr_ff, cause_ff, nxt_cause;
  logic [4:0] wd_period_ff;
  logic [10:0] period_ms_ff;
  logic [2:0] last_cs_ff;

  assign nxt_cause = RESTART_SET ? RESTART_CODE : (clr_cause ? CAUSE_NONE : cause_ff);

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      lin_low_slope_ff <= RST_LIN_SLOPE;
      can_mode_ff <= RST_CELL_MODE;
      lin_mode_ff <= RST_CELL_MODE;
    end else if (wr_comm) begin
      lin_low_slope_ff <= frame_ff[COMM_SLOPE_BIT];
      can_mode_ff <= frame_ff[CAN_MODE_LSB +: 2];
      lin_mode_ff <= frame_ff[LIN_MODE_LSB +: 2];
    end
  end

  // watchdog set-up, reserved bit not stored
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      wd_type_ff <= RST_WD_TYPE;
      wd_en_ff <= RST_WD_ENABLE;
      wd_period_ff <= RST_WD_PERIOD;
    end else if (wr_wd) begin
      wd_type_ff <= frame_ff[WD_TYPE_BIT];
      wd_en_ff <= frame_ff[WD_ENABLE_BIT];
      wd_period_ff <= frame_ff[WD_PERIOD_LSB +: 5];
    end
  end

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      period_ms_ff <= RST_PERIOD_MS;
    end else begin
      period_ms_ff <= period_ms(wd_period_ff);
    end
  end

  // threshold, restart cause, trigger and last select
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      thr_ff <= RST_THRESHOLD;
      cause_ff <= CAUSE_NONE;
      wd_trig_ff <= 1'b0;
      last_cs_ff <= CS_CONFIG;
    end else begin
      if (wr_thr) begin
        thr_ff <= f_thr;
      end
      cause_ff <= nxt_cause;
      wd_trig_ff <= frame_ev;
      if (frame_ev) begin
        last_cs_ff <= f_cs;
      end
    end
  end

  // ---------------------------------------------------------------
  // Shadow copies, refreshed only while deselected
  // ---------------------------------------------------------------
  logic wd_chk_out;

  // Check bit sent back is consistent with the stored settings
  assign wd_chk_out = ^{1'b1, wd_en_ff, 1'b0, wd_period_ff};

  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sh_cfg_ff <= 10'h000;
      sh_comm_ff <= 10'h000;
      sh_wd_ff <= 10'h000;
      sh_diag_ff <= 10'h000;
      sh_cs_ff <= CS_CONFIG;
    end else if (csn_s2_ff) begin
      sh_cfg_ff <= {8'h00, thr_ff};
      sh_comm_ff <= {5'h00, lin_low_slope_ff, can_mode_ff, lin_mode_ff};
      sh_wd_ff <= {wd_chk_out, wd_type_ff, 1'b1, wd_en_ff, 1'b0, wd_period_ff};
      sh_diag_ff <= {2'h0, CONFIG_READOUT, LIMP_CAUSE, cause_ff};
      sh_cs_ff <= last_cs_ff;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign LIN_LOW_SLOPE = lin_low_slope_ff;
  assign CAN_MODE = can_mode_ff;
  assign LIN_MODE = lin_mode_ff;
  assign WD_TIMEOUT_MODE = wd_type_ff;
  assign WD_ENABLE = wd_en_ff;
  assign WD_PERIOD_MS = period_ms_ff;
  assign RESET_THRESHOLD = thr_ff;
  assign RESTART_CAUSE = cause_ff;
  assign WD_TRIGGER = wd_trig_ff;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);

  sequence s_comm_write;
    frame_ev && !f_ro && f_cs == CS_COMM;
  endsequence

  sequence s_ro_frame;
    frame_ev && f_ro;
  endsequence

  sequence s_thr_write;
    frame_ev && !f_ro && f_cs == CS_CONFIG && f_thr != THR_INVALID;
  endsequence

  a_slope_write: assert property (s_comm_write |=>
    LIN_LOW_SLOPE == $past(frame_ff[COMM_SLOPE_BIT])) else $error("slope not written");
  a_can_write: assert property (s_comm_write |=>
    CAN_MODE == $past(frame_ff[9:8])) else $error("CAN mode not written");
  a_lin_write: assert property (s_comm_write |=>
    LIN_MODE == $past(frame_ff[7:6])) else $error("LIN mode not written");
  a_wd_enable_write: assert property (wr_wd |=>
    WD_ENABLE == $past(frame_ff[WD_ENABLE_BIT]) && WD_TIMEOUT_MODE == $past(frame_ff[14]))
    else $error("watchdog set-up not written");
  a_wd_chk_reject: assert property (frame_ev && !f_ro && f_cs == CS_WATCHDOG && !wd_chk_ok
    |=> $stable(WD_ENABLE) && $stable(WD_TIMEOUT_MODE) && $stable(wd_period_ff))
    else $error("bad check bit accepted");
  a_thr_reject: assert property (frame_ev && f_cs == CS_CONFIG && f_thr == 2'h0
    |=> $stable(RESET_THRESHOLD)) else $error("threshold 00 accepted");
  a_period_map: assert property (wr_wd |=> ##1
    WD_PERIOD_MS == period_ms($past(frame_ff[10:6], 2))) else $error("period mismatch");
  a_ro_no_write: assert property (s_ro_frame |=>
    $stable(CAN_MODE) && $stable(LIN_MODE) && $stable(WD_ENABLE) && $stable(RESET_THRESHOLD)
    && WD_TRIGGER) else $error("read-only frame changed settings");
  a_cause_ro_clear: assert property (s_ro_frame ##0 (f_cs == CS_DIAG && !RESTART_SET)
    |=> RESTART_CAUSE == 2'h0) else $error("cause not cleared by read");
  a_cause_exit_clear: assert property (MODE_EXIT && !RESTART_SET
    |=> RESTART_CAUSE == 2'h0) else $error("cause not cleared on exit");
  a_cause_set_wins: assert property (RESTART_SET
    |=> RESTART_CAUSE == $past(RESTART_CODE)) else $error("cause set lost");
  a_diag_no_write: assert property (frame_ev && f_cs == CS_DIAG
    |=> $stable(CAN_MODE) && $stable(WD_ENABLE) && $stable(RESET_THRESHOLD))
    else $error("diagnosis frame wrote settings");
  a_thr_write: assert property (s_thr_write |=>
    RESET_THRESHOLD == $past(f_thr)) else $error("threshold not written");
  // Stored settings move only on an accepted write or event
  a_cause_hold: assert property (!RESTART_SET && !clr_cause
    |=> $stable(RESTART_CAUSE)) else $error("cause changed without event");
  a_comm_hold: assert property (!wr_comm |=> $stable(CAN_MODE) && $stable(LIN_MODE)
    && $stable(LIN_LOW_SLOPE)) else $error("comm set-up changed without write");
  a_wd_hold: assert property (!wr_wd |=> $stable(WD_ENABLE) && $stable(WD_TIMEOUT_MODE))
    else $error("watchdog set-up changed without write");
  a_period_hold: assert property (!wr_wd |=> ##1 $stable(WD_PERIOD_MS))
    else $error("period changed without write");
  a_sdo_idle: assert property (CS_N |-> !SDO)
    else $error("serial output not idle while deselected");

endmodule

// file: rtl/sbc_cfg_pkg.sv
// Constants for the serial configuration and diagnosis register block
package sbc_cfg_pkg;
  // ---------------------------------------------------------------
  // Frame layout, LSB first on the wire
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 16;
  localparam int MS_LSB = 0;
  localparam int CS_LSB = 3;
  localparam int DATA_LSB = 6;
  localparam int DATA_BITS = 10;
  // ---------------------------------------------------------------
  // Configuration select and mode select codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CS_CONFIG = 3'h4;
  localparam logic [2:0] CS_COMM = 3'h5;
  localparam logic [2:0] CS_WATCHDOG = 3'h6;
  localparam logic [2:0] CS_DIAG = 3'h7;
  localparam logic [2:0] MS_READ_ONLY = 3'h7;
  // ---------------------------------------------------------------
  // Field positions inside the frame
  // ---------------------------------------------------------------
  localparam int COMM_SLOPE_BIT = 10;
  localparam int CAN_MODE_LSB = 8;
  localparam int LIN_MODE_LSB = 6;
  localparam int WD_CHECK_BIT = 15;
  localparam int WD_TYPE_BIT = 14;
  localparam int WD_ENABLE_BIT = 12;
  localparam int WD_PERIOD_LSB = 6;
  localparam int CHK_HI = 13;
  localparam int CHK_LO = 6;
  localparam int THR_LSB = 6;
  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic RST_LIN_SLOPE = 1'h1;
  localparam logic [1:0] RST_CELL_MODE = 2'h0;
  localparam logic RST_WD_TYPE = 1'h1;
  localparam logic RST_WD_ENABLE = 1'h1;
  localparam logic [4:0] RST_WD_PERIOD = 5'h0F;
  localparam logic [1:0] RST_THRESHOLD = 2'h1;
  localparam logic [1:0] THR_INVALID = 2'h0;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  // ---------------------------------------------------------------
  // Watchdog period arithmetic, in ms
  // ---------------------------------------------------------------
  localparam logic [10:0] PERIOD_STEP_LO = 11'h010;
  localparam logic [10:0] PERIOD_STEP_HI = 11'h030;
  localparam logic [10:0] PERIOD_OFFSET = 11'h1D0;
  localparam logic [10:0] RST_PERIOD_MS = 11'h100;
endpackage

// file: verification/sbc_host_model.sv
// Host serial master model that frames commands to the register block
`timescale 1ns/1ps
module sbc_host_model (
  output logic sclk,
  output logic cs_n,
  output logic sdi,
  input wire logic sdo
);
  logic [15:0] rx;
  // ---------------------------------------------------------------
  // Idle levels: serial clock stands still, select released
  // ---------------------------------------------------------------
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
  end
  // Shift one frame LSB first, capture the answer on each rising edge
  task automatic frame(input logic [15:0] tx, input int edges);
    rx = 16'h0000;
    cs_n = 1'b0;
    #17.3;
    for (int i = 0; i < edges; i++) begin
      sdi = tx[i];
      #16;
      sclk = 1'b1;
      rx[i] = sdo;
      #32;
      sclk = 1'b0;
      #16;
    end
    // Released data line shows the inverse of its last value
    sdi = ~sdi;
    cs_n = 1'b1;
    #48;
  endtask
endmodule

// file: verification/sbc_config_diag_encoder_test.sv
// Self-checking bench for the configuration and diagnosis register block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module sbc_config_diag_encoder_test;
  import sbc_cfg_pkg::*;
  // ---------------------------------------------------------------
  // Stimulus, design outputs and reference model state
  // ---------------------------------------------------------------
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic set = 1'b0;
  logic mexit = 1'b0;
  logic [1:0] code = 2'h0;
  logic [2:0] limp = 3'h0;
  logic [2:0] cfgro = 3'h0;
  wire sclk;
  wire cs_n;
  wire sdi;
  wire sdo;
  logic slope, wtype, wen, trig;
  logic [1:0] can, lin, thr, cause;
  logic [10:0] per_ms;
  logic e_slope, e_type, e_en;
  logic [1:0] e_can, e_lin, e_thr, e_cause;
  logic [4:0] e_per;
  logic [2:0] e_cs;
  logic [31:0] lf = 32'h84be_6b3f;
  logic [1:0] thv [5] = '{2'h2, 2'h0, 2'h3, 2'h1, 2'h0};
  int n_fail = 0;
  int n_tests = 0;
  int n_frames = 0;
  int n_trig = 0;

  sbc_host_model host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));
  sbc_config_diag_encoder DUT (.MCLK(mclk), .RST(rst), .SCLK(sclk), .CS_N(cs_n), .SDI(sdi),
    .SDO(sdo), .RESTART_SET(set), .RESTART_CODE(code), .MODE_EXIT(mexit),
    .LIMP_CAUSE(limp), .CONFIG_READOUT(cfgro), .LIN_LOW_SLOPE(slope), .CAN_MODE(can),
    .LIN_MODE(lin), .WD_TIMEOUT_MODE(wtype), .WD_ENABLE(wen), .WD_PERIOD_MS(per_ms),
    .RESET_THRESHOLD(thr), .RESTART_CAUSE(cause), .WD_TRIGGER(trig));

  // System clock and frame trigger counter
  always #2 mclk = ~mclk;
  always @(posedge mclk) n_trig += int'(trig === 1'b1);

  function automatic logic [31:0] lfsr;
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf;
  endfunction
  function automatic logic [2:0] rms;
    logic [31:0] v;
    v = lfsr();
    return v[2:0] == 3'h7 ? 3'h0 : v[2:0];
  endfunction
  function automatic int pms(int n);
    return n < 16 ? (n + 1) * 16 : n * 48 - 464;
  endfunction
  // reserved bit one, check over bits 13 to 6
  function automatic logic [9:0] wdd(logic t, logic en, logic [4:0] p, logic good);
    return {^{1'b1, en, 1'b0, p} ^ ~good, t, 1'b1, en, 1'b0, p};
  endfunction
  function automatic logic [15:0] expd(logic [2:0] s);
    return s == CS_CONFIG ? {8'h00, e_thr, 6'h00}
      : s == CS_COMM ? {5'h00, e_slope, e_can, e_lin, 6'h00}
      : s == CS_WATCHDOG ? {wdd(e_type, e_en, e_per, 1'b1), 6'h00}
      : s == CS_DIAG ? {2'h0, cfgro, limp, e_cause, 6'h00} : 16'h0000;
  endfunction
  function automatic logic [15:0] mask(logic [2:0] s);
    return s == CS_CONFIG ? 16'h00FF : s == CS_COMM ? 16'h07FF : s == CS_WATCHDOG ? 16'hF7FF
      : s == CS_DIAG ? 16'h3FFF : 16'h003F;
  endfunction

  task automatic chk_out;
    `CHK("slope", e_slope, slope)
    `CHK("can", e_can, can)
    `CHK("lin", e_lin, lin)
    `CHK("wdtype", {e_type, e_en}, {wtype, wen})
    `CHK("period", pms(e_per), per_ms)
    `CHK("thr", e_thr, thr)
    `CHK("cause", e_cause, cause)
    `CHK("trig", n_frames, n_trig)
  endtask
  task automatic rst_dut;
    @(posedge mclk) #1;
    rst = 1'b1;
    repeat (5) @(posedge mclk);
    #1;
    rst = 1'b0;
    // every field back to its default
    {e_slope, e_can, e_lin, e_type, e_en, e_per} = {1'b1, 4'h0, 2'h3, 5'h0F};
    {e_thr, e_cause, e_cs} = {2'h1, 2'h0, 3'h4};
    repeat (4) @(posedge mclk);
  endtask
  // One full frame, readout compared, model updated, outputs compared
  task automatic cmd(input logic [2:0] m, input logic [2:0] s, input logic [9:0] d);
    logic [31:0] r;
    logic [2:0] rs;
    r = lfsr();
    @(posedge mclk) #1;
    limp = r[2:0];
    cfgro = r[5:3];
    repeat (3) @(posedge mclk);
    #1;
    rs = (m == MS_READ_ONLY) ? s : e_cs;
    host.frame({d, s, m}, 16);
    `CHK("readout", (expd(rs) | {10'h000, e_cs, 3'h0}) & mask(rs), host.rx & mask(rs))
    if (m != MS_READ_ONLY && s == CS_COMM)
      {e_slope, e_can, e_lin} = d[4:0];
    if (m != MS_READ_ONLY && s == CS_WATCHDOG && d[9] == ^d[7:0])
      {e_type, e_en, e_per} = {d[8], d[6], d[4:0]};
    if (m != MS_READ_ONLY && s == CS_CONFIG && d[1:0] != 2'h0)
      e_thr = d[1:0];
    if (m == MS_READ_ONLY && s == CS_DIAG)
      e_cause = 2'h0;
    e_cs = s;
    n_frames++;
    chk_out();
  endtask
  task automatic ev(input logic s, input logic [1:0] c, input logic x);
    @(posedge mclk) #1;
    set = s;
    code = c;
    mexit = x;
    @(posedge mclk) #1;
    set = 1'b0;
    mexit = 1'b0;
    repeat (2) @(posedge mclk);
    #1;
    // mode exit clears, a new cause wins
    e_cause = s ? c : x ? 2'h0 : e_cause;
    `CHK("cause", e_cause, cause)
  endtask
  task automatic results;
    $display("tests %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Main sequence and hang limit
  // ---------------------------------------------------------------
  initial begin
    #300000;
    n_fail++;
    results();
  end
  initial begin
    logic [31:0] r;
    rst_dut();
    chk_out();
    cmd(MS_READ_ONLY, CS_CONFIG, 10'h000);
    for (int i = 0; i < 16; i++) begin
      r = lfsr();
      cmd(rms(), CS_COMM, {5'h00, r[8], i[3:0]});
    end
    for (int i = 0; i < 32; i++) begin
      r = lfsr();
      cmd(rms(), CS_WATCHDOG, wdd(r[0], r[1], i[4:0], 1'b1));
    end
    cmd(rms(), CS_WATCHDOG, wdd(1'b0, 1'b0, 5'h03, 1'b0));
    foreach (thv[k]) cmd(rms(), CS_CONFIG, {8'h00, thv[k]});
    cmd(MS_READ_ONLY, CS_COMM, 10'h3FF);
    cmd(MS_READ_ONLY, CS_WATCHDOG, wdd(1'b0, 1'b0, 5'h01, 1'b1));
    for (int i = 0; i < 4; i++) cmd(rms(), i[2:0], 10'h3FF);
    cmd(3'h0, CS_DIAG, 10'h3FF);
    host.frame({10'h3FF, CS_COMM, 3'h0}, 15);
    chk_out();
    for (int c = 1; c < 4; c++) begin
      ev(1'b1, c[1:0], 1'b0);
      cmd(MS_READ_ONLY, CS_DIAG, 10'h000);
    end
    ev(1'b1, 2'h2, 1'b0);
    cmd(3'h0, CS_DIAG, 10'h000);
    cmd(3'h0, CS_COMM, 10'h000);
    ev(1'b0, 2'h0, 1'b1);
    ev(1'b1, 2'h3, 1'b1);
    rst_dut();
    chk_out();
    cmd(3'h1, CS_COMM, 10'h01B);
    results();
  end
endmodule
